// ===== design/power_sleep_reset_control.sv
// Added by the designer: the APB register port.
`timescale 1ns/1ns
module power_sleep_reset_control
   import power_sleep_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sleep_instr,
   input wire logic wake_event,
   input wire logic power_on_detect,
   input wire logic brownout_low,
   input wire logic brownout_fuse_enable,
   input wire logic reset_pin_n,
   input wire logic reset_pin_disable_fuse,
   input wire logic watchdog_reset_pulse,
   input wire logic [1:0] startup_time_fuses,
   input wire logic [3:0] clock_select_fuses,
   input wire logic timer_zero_async_select,
   output logic sleeping,
   output logic [1:0] sleep_mode,
   output logic brownout_detector_off,
   output logic [5:0] periph_clk_en,
   output logic adc_mux_available,
   output logic io_reset_n,
   output logic core_reset_n
);

   initial begin
      if (ADDR_W < 8) $error("ADDR_W must cover the 8-bit register decode");
   end

   typedef struct packed {
      logic sleep_enable_bit;
      logic [1:0] sleep_mode_select;
      logic sleep_brownout_disable;
      logic [2:0] window_cnt;
      logic [2:0] disable_cnt;
      logic sleeping;
      logic [1:0] mode;
      logic bod_off;
      logic [5:0] gate;
      logic [3:0] flags;
      logic [7:0] rdata;
      logic err;
   } state_type;

   state_type st_q, st_d;

   logic pin_low_raw;
   logic brownout_raw;
   logic sources_idle_n;
   logic stretch_active;
   logic int_reset;
   logic [2:0] filt;
   logic [11:0] timeout;
   logic disable_active;
   logic wr_access;
   logic setup;
   logic [7:0] wbyte;
   logic [7:0] addr8;

   ////////////////////////////////////////////////////////////////////////
   // Reset sources and stretching

   assign pin_low_raw = !reset_pin_n && !reset_pin_disable_fuse;
   // detector enabled by its fuse unless off in sleep
   assign brownout_raw = brownout_low && brownout_fuse_enable && !st_q.bod_off;
   assign sources_idle_n = presetn && !power_on_detect && !pin_low_raw && !brownout_raw;
   assign io_reset_n = sources_idle_n;

   assign timeout = STARTUP_BASE_CYCLES << {clock_select_fuses[0], startup_time_fuses};

   reset_stretch #(
      .CNT_W(12)
   ) u_stretch (
      .pclk(pclk),
      .sources_idle_n(sources_idle_n),
      .hold(watchdog_reset_pulse),
      .timeout(timeout),
      .reset_active(stretch_active)
   );

   assign int_reset = stretch_active;
   assign core_reset_n = !int_reset;

   // Flags need the source level in the clock domain, filtered against glitches
   input_filter #(
      .WIDTH(3),
      .RESET_VALUE(3'h0)
   ) u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({power_on_detect, brownout_raw, pin_low_raw}),
      .filtered(filt)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus decode

   assign setup = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   assign wbyte = pwdata[7:0];
   assign addr8 = paddr[7:0];
   assign disable_active = st_q.sleep_brownout_disable && (st_q.disable_cnt >= DISABLE_DELAY_CYCLES);

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      st_d = st_q;

      // Read data and error latched in the setup cycle
      if (setup) begin
         st_d.err = 1'b0;
         st_d.rdata = 8'h00;
         case (addr8)
            OFF_SLEEP_MODE_CONTROL: st_d.rdata = {5'h00, st_q.sleep_mode_select, st_q.sleep_enable_bit};
            OFF_SYSTEM_CONTROL: st_d.rdata = {1'b0, st_q.sleep_brownout_disable, st_q.window_cnt != 3'h0, 5'h00};
            OFF_RESET_CAUSE_FLAGS: st_d.rdata = {4'h0, st_q.flags};
            OFF_PERIPHERAL_CLOCK_GATING: st_d.rdata = {2'h0, st_q.gate};
            default: st_d.err = 1'b1;
         endcase
      end

      // Timed change window and disable bit lifetime
      if (st_q.window_cnt != 3'h0) begin
         st_d.window_cnt = st_q.window_cnt - 3'h1;
      end
      // active after delay, auto clear after hold
      if (st_q.sleep_brownout_disable) begin
         if (st_q.disable_cnt == DISABLE_DELAY_CYCLES + DISABLE_HOLD_CYCLES - 3'h1) begin
            st_d.sleep_brownout_disable = 1'b0;
            st_d.disable_cnt = 3'h0;
         end else begin
            st_d.disable_cnt = st_q.disable_cnt + 3'h1;
         end
      end

      if (wr_access) begin
         case (addr8)
            OFF_SLEEP_MODE_CONTROL: begin
               st_d.sleep_enable_bit = wbyte[SLEEP_ENABLE_BIT];
               st_d.sleep_mode_select = wbyte[SLEEP_MODE_LSB +: 2];
            end
            OFF_SYSTEM_CONTROL: begin
               if (wbyte[BROWNOUT_DISABLE_BIT] && wbyte[CHANGE_ENABLE_BIT]) begin
                  st_d.window_cnt = CHANGE_WINDOW_CYCLES;
               end else if (wbyte[BROWNOUT_DISABLE_BIT] && (st_q.window_cnt != 3'h0)) begin
                  st_d.window_cnt = 3'h0;
                  st_d.sleep_brownout_disable = 1'b1;
                  st_d.disable_cnt = 3'h0;
               end
            end
            OFF_PERIPHERAL_CLOCK_GATING: st_d.gate = wbyte[5:0];
            OFF_RESET_CAUSE_FLAGS: st_d.flags = st_q.flags & wbyte[3:0];
            default: ;
         endcase
      end

      // source events set flags, set wins over write
      if (watchdog_reset_pulse) st_d.flags[WATCHDOG_FLAG_BIT] = 1'b1;
      if (filt[1]) st_d.flags[BROWNOUT_FLAG_BIT] = 1'b1;
      if (filt[0]) st_d.flags[EXTERNAL_FLAG_BIT] = 1'b1;
      // power-on sets its flag, clears others
      if (filt[2]) st_d.flags = CAUSE_POWER_ON_RESET;

      // Sleep entry and wake
      if (wake_event) begin
         st_d.sleeping = 1'b0;
         st_d.bod_off = 1'b0;
      end else if (sleep_instr && !st_q.sleeping) begin
         if (st_q.sleep_enable_bit) begin
            st_d.sleeping = 1'b1;
            st_d.mode = st_q.sleep_mode_select;
            st_d.bod_off = disable_active;
         end
      end

      if (int_reset) begin
         st_d.sleep_enable_bit = 1'b0;
         st_d.sleep_mode_select = SLEEP_MODE_RESET;
         st_d.sleep_brownout_disable = 1'b0;
         st_d.window_cnt = 3'h0;
         st_d.disable_cnt = 3'h0;
         st_d.sleeping = 1'b0;
         st_d.mode = SLEEP_MODE_RESET;
         st_d.bod_off = 1'b0;
         st_d.gate = GATING_RESET;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= '{flags: CAUSE_POWER_ON_RESET, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign prdata = {24'h000000, st_q.rdata};
   assign pready = 1'b1;
   assign pslverr = psel && penable && st_q.err;
   assign sleeping = st_q.sleeping;
   assign sleep_mode = st_q.mode;
   assign brownout_detector_off = st_q.bod_off;

   // A low enable also blocks the peripheral's register access
   always_comb begin
      periph_clk_en = ~st_q.gate;
      // timer zero gate only when synchronous
      periph_clk_en[GATE_TIMER_ZERO_BIT] = !(st_q.gate[GATE_TIMER_ZERO_BIT] && !timer_zero_async_select);
   end

   // comparator loses mux when ADC gated
   assign adc_mux_available = !st_q.gate[GATE_ADC_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_reserved_zero;
      setup && (addr8 == OFF_SLEEP_MODE_CONTROL) |=> st_q.rdata[7:3] == 5'h00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved sleep bits not zero");

   property p_no_sleep_without_enable;
      !st_q.sleeping && sleep_instr && !st_q.sleep_enable_bit |=> !st_q.sleeping;
   endproperty
   a_no_sleep_without_enable: assert property (p_no_sleep_without_enable) else $error("slept without enable");

   property p_mode_taken;
      !st_q.sleeping && sleep_instr && st_q.sleep_enable_bit && !wake_event && !int_reset
         |=> st_q.sleeping && (st_q.mode == $past(st_q.sleep_mode_select));
   endproperty
   a_mode_taken: assert property (p_mode_taken) else $error("sleep mode not taken");

   property p_disable_needs_window;
      $rose(st_q.sleep_brownout_disable) |-> $past(st_q.window_cnt) != 3'h0;
   endproperty
   a_disable_needs_window: assert property (p_disable_needs_window) else $error("disable set outside window");

   property p_disable_timing;
      $rose(st_q.sleep_brownout_disable) && !int_reset |-> !disable_active [*3] ##1 disable_active [*3]
         ##1 !st_q.sleep_brownout_disable;
   endproperty
   a_disable_timing: assert property (p_disable_timing) else $error("disable bit timing wrong");

   property p_bod_off_follows;
      !st_q.sleeping && sleep_instr && st_q.sleep_enable_bit && !wake_event && !int_reset
         |=> st_q.bod_off == $past(disable_active);
   endproperty
   a_bod_off_follows: assert property (p_bod_off_follows) else $error("detector off state wrong");

   property p_timer_gates;
      st_q.gate[GATE_TIMER_ONE_BIT] |-> !periph_clk_en[GATE_TIMER_ONE_BIT];
   endproperty
   a_timer_gates: assert property (p_timer_gates) else $error("timer one not frozen");

   property p_adc_gate;
      st_q.gate[GATE_ADC_BIT] |-> !adc_mux_available && !periph_clk_en[GATE_ADC_BIT];
   endproperty
   a_adc_gate: assert property (p_adc_gate) else $error("adc gate ignored");

   // Live source must keep the core held whatever the counter does
   property p_source_holds_core;
      !io_reset_n |-> !core_reset_n;
   endproperty
   a_source_holds_core: assert property (p_source_holds_core) else $error("core ran during reset source");

   property p_gates_cleared;
      int_reset |=> st_q.gate == GATING_RESET;
   endproperty
   a_gates_cleared: assert property (p_gates_cleared) else $error("gates not cleared by reset");

   property p_watchdog_holds;
      watchdog_reset_pulse |=> int_reset && st_q.flags[WATCHDOG_FLAG_BIT];
   endproperty
   a_watchdog_holds: assert property (p_watchdog_holds) else $error("watchdog reset not seen");

   property p_write_never_sets;
      !watchdog_reset_pulse && (filt == 3'h0) |=> (st_q.flags & ~$past(st_q.flags)) == 4'h0;
   endproperty
   a_write_never_sets: assert property (p_write_never_sets) else $error("flag set without source");

   property p_zero_clears;
      wr_access && (addr8 == OFF_RESET_CAUSE_FLAGS) && !wbyte[POWER_ON_FLAG_BIT] && (filt[2] == 1'b0)
         |=> !st_q.flags[POWER_ON_FLAG_BIT];
   endproperty
   a_zero_clears: assert property (p_zero_clears) else $error("power-on flag not cleared");

endmodule : power_sleep_reset_control

// ===== design/power_sleep_pkg.sv
package power_sleep_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFF_SLEEP_MODE_CONTROL = 8'h50;
   localparam logic [7:0] OFF_SYSTEM_CONTROL = 8'h54;
   localparam logic [7:0] OFF_RESET_CAUSE_FLAGS = 8'h58;
   localparam logic [7:0] OFF_PERIPHERAL_CLOCK_GATING = 8'h64;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int SLEEP_ENABLE_BIT = 0;
   localparam int SLEEP_MODE_LSB = 1;
   localparam int CHANGE_ENABLE_BIT = 5;
   localparam int BROWNOUT_DISABLE_BIT = 6;
   localparam int GATE_ADC_BIT = 0;
   localparam int GATE_UNIVERSAL_SERIAL_BIT = 1;
   localparam int GATE_TIMER_ZERO_BIT = 2;
   localparam int GATE_TIMER_ONE_BIT = 3;
   localparam int GATE_SPI_BIT = 4;
   localparam int GATE_LIN_UART_BIT = 5;
   localparam int POWER_ON_FLAG_BIT = 0;
   localparam int EXTERNAL_FLAG_BIT = 1;
   localparam int BROWNOUT_FLAG_BIT = 2;
   localparam int WATCHDOG_FLAG_BIT = 3;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [1:0] SLEEP_MODE_RESET = 2'h0;
   localparam logic [5:0] GATING_RESET = 6'h00;
   localparam logic [3:0] CAUSE_POWER_ON_RESET = 4'h1;

   ////////////////////////////////////////////////////////////////////////
   // Timing counts, in clock cycles
   localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;
   localparam logic [2:0] DISABLE_DELAY_CYCLES = 3'h3;
   localparam logic [2:0] DISABLE_HOLD_CYCLES = 3'h3;
   localparam logic [11:0] STARTUP_BASE_CYCLES = 12'h010;

   typedef enum logic [1:0] {
      MODE_IDLE,
      MODE_ADC_NOISE_REDUCTION,
      MODE_POWER_DOWN,
      MODE_POWER_SAVE
   } sleep_mode_type;

endpackage : power_sleep_pkg

// ===== design/input_filter.sv
`timescale 1ns/1ns
module input_filter
   import power_sleep_pkg::*;
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] filtered
);

   initial begin
      if (WIDTH < 1) $error("input_filter needs WIDTH of at least 1");
   end

   typedef struct packed {
      logic [WIDTH-1:0] stage1;
      logic [WIDTH-1:0] stage2;
      logic [WIDTH-1:0] stage3;
      logic [WIDTH-1:0] out;
   } filter_state_type;

   filter_state_type st_q, st_d;

   // Stage one feeds stage two only; a change counts once two and three agree
   always_comb begin
      st_d = st_q;
      st_d.stage1 = async_in;
      st_d.stage2 = st_q.stage1;
      st_d.stage3 = st_q.stage2;
      for (int i = 0; i < WIDTH; i++) begin
         if (st_q.stage2[i] == st_q.stage3[i]) begin
            st_d.out[i] = st_q.stage3[i];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= {RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
      end else begin
         st_q <= st_d;
      end
   end

   assign filtered = st_q.out;

endmodule : input_filter

// ===== design/reset_stretch.sv
`timescale 1ns/1ns
module reset_stretch
   import power_sleep_pkg::*;
#(
   parameter int CNT_W = 12
) (
   input wire logic pclk,
   input wire logic sources_idle_n,
   input wire logic hold,
   input wire logic [CNT_W-1:0] timeout,
   output logic reset_active
);

   initial begin
      if (CNT_W < 2) $error("reset_stretch needs CNT_W of at least 2");
   end

   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic active;
   } stretch_state_type;

   stretch_state_type st_q, st_d;

   always_comb begin
      st_d = st_q;
      if (hold) begin
         st_d.count = '0;
         st_d.active = 1'b1;
      end else if (st_q.active) begin
         if (st_q.count >= timeout - 1'b1) begin
            st_d.active = 1'b0;
         end else begin
            st_d.count = st_q.count + 1'b1;
         end
      end
   end

   // Asserts at once from any live source; release only by counting
   always_ff @(posedge pclk or negedge sources_idle_n) begin
      if (!sources_idle_n) begin
         st_q <= '{count: '0, active: 1'b1};
      end else begin
         st_q <= st_d;
      end
   end

   assign reset_active = st_q.active;

endmodule : reset_stretch

// ===== bench/core_model.sv
`timescale 1ns/1ns
module core_model
   import power_sleep_pkg::*;
(
   input wire logic pclk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   output logic sleep_instr,
   output logic wake_event
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sleep_instr = 1'b0;
      wake_event = 1'b0;
   end

   ////////////////////////////////////////////////////////////
   // Entered just after an edge; hold keeps psel up for a back-to-back transfer
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       input logic hold, output logic [31:0] rdata, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdata = prdata;
      err = pslverr;
      penable <= 1'b0;
      if (!hold) begin
         psel <= 1'b0;
         // Released lines do not keep their old value
         paddr <= ~addr;
         pwdata <= ~wdata;
      end
   endtask : xfer

   // One-cycle pulses, entered just after an edge
   task automatic sleep_op();
      sleep_instr <= 1'b1;
      @(posedge pclk);
      sleep_instr <= 1'b0;
   endtask : sleep_op

   task automatic wake_op();
      wake_event <= 1'b1;
      @(posedge pclk);
      wake_event <= 1'b0;
   endtask : wake_op

   task automatic brownout_off_seq();
      logic [31:0] r;
      logic e;
      xfer(1'b1, OFF_SYSTEM_CONTROL, 32'h60, 1'b1, r, e);
      xfer(1'b1, OFF_SYSTEM_CONTROL, 32'h40, 1'b0, r, e);
   endtask : brownout_off_seq
endmodule : core_model

// ===== bench/power_sleep_reset_control_tb.sv
`timescale 1ns/1ns
module power_sleep_reset_control_tb
   import power_sleep_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, sleep_instr, wake_event, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic power_on_detect = 1'b0;
   logic brownout_low = 1'b0;
   logic brownout_fuse_enable = 1'b0;
   logic reset_pin_n = 1'b1;
   logic reset_pin_disable_fuse = 1'b0;
   logic watchdog_reset_pulse = 1'b0;
   logic timer_zero_async_select = 1'b0;
   logic sleeping, brownout_detector_off, adc_mux_available, io_reset_n, core_reset_n;
   logic [1:0] sleep_mode;
   logic [5:0] periph_clk_en;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;

   always #5 pclk = ~pclk;

   // Fuses fixed at the shortest stretch of 16 cycles
   power_sleep_reset_control dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_instr(sleep_instr), .wake_event(wake_event), .power_on_detect(power_on_detect),
      .brownout_low(brownout_low), .brownout_fuse_enable(brownout_fuse_enable),
      .reset_pin_n(reset_pin_n), .reset_pin_disable_fuse(reset_pin_disable_fuse),
      .watchdog_reset_pulse(watchdog_reset_pulse), .startup_time_fuses(2'h0),
      .clock_select_fuses(4'h0), .timer_zero_async_select(timer_zero_async_select),
      .sleeping(sleeping), .sleep_mode(sleep_mode), .brownout_detector_off(brownout_detector_off),
      .periph_clk_en(periph_clk_en), .adc_mux_available(adc_mux_available),
      .io_reset_n(io_reset_n), .core_reset_n(core_reset_n)
   );

   core_model core (
      .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleep_instr(sleep_instr), .wake_event(wake_event)
   );

   ////////////////////////////////////////////////////////////
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask : chk_bit

   task automatic stop_test();
      $display("mismatches=%0d checks=%0d", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      core.xfer(1'b1, a, d, 1'b0, rd, er);
   endtask : wr

   task automatic rd_reg(input logic [7:0] a);
      @(posedge pclk);
      core.xfer(1'b0, a, 32'h0, 1'b0, rd, er);
   endtask : rd_reg

   task automatic wait_core();
      n = 0;
      while (core_reset_n !== 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      chk_bit(core_reset_n, 1'b1);
   endtask : wait_core

   task automatic wake();
      @(posedge pclk);
      core.wake_op();
      #1;
      chk_bit(sleeping, 1'b0);
   endtask : wake

   // Source held 8 cycles: 0 pin, 1 brown-out, else power-on
   task automatic hit(input int which, input logic fires);
      @(posedge pclk);
      case (which)
         0: reset_pin_n <= 1'b0;
         1: brownout_low <= 1'b1;
         default: power_on_detect <= 1'b1;
      endcase
      #2;
      chk_bit(io_reset_n, !fires);
      chk_bit(core_reset_n, !fires);
      repeat (8) @(posedge pclk);
      reset_pin_n <= 1'b1;
      brownout_low <= 1'b0;
      power_on_detect <= 1'b0;
      wait_core();
      if (fires)
         chk_bit(n >= 16 && n <= 24, 1'b1);
   endtask : hit

   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      wait_core();
      chk_bit(n >= 15 && n <= 18, 1'b1);
      chk_word({26'h0, periph_clk_en}, 32'h3F);
      rd_reg(OFF_SLEEP_MODE_CONTROL);
      chk_word(rd, 32'h0);
      rd_reg(OFF_RESET_CAUSE_FLAGS);
      chk_word(rd, 32'h1);
      rd_reg(OFF_PERIPHERAL_CLOCK_GATING);
      chk_word(rd, 32'h0);
      chk_bit(er, 1'b0);
      wr(8'h70, 32'hFF);
      rd_reg(8'h70);
      chk_word(rd, 32'h0);
      chk_bit(er, 1'b1);
   endtask : t_reset

   task automatic t_gating();
      wr(OFF_SLEEP_MODE_CONTROL, 32'hFF);
      rd_reg(OFF_SLEEP_MODE_CONTROL);
      chk_word(rd, 32'h07);
      for (int i = 0; i < 6; i++) begin
         wr(OFF_PERIPHERAL_CLOCK_GATING, 32'h1 << i);
         #1;
         chk_word({26'h0, periph_clk_en}, {26'h0, ~(6'h01 << i)});
         chk_bit(adc_mux_available, i != 0);
      end
      @(posedge pclk);
      timer_zero_async_select <= 1'b1;
      wr(OFF_PERIPHERAL_CLOCK_GATING, 32'hFF);
      #1;
      chk_word({26'h0, periph_clk_en}, 32'h04);
      rd_reg(OFF_PERIPHERAL_CLOCK_GATING);
      chk_word(rd, 32'h3F);
      wr(OFF_PERIPHERAL_CLOCK_GATING, 32'h0);
      #1;
      chk_word({26'h0, periph_clk_en}, 32'h3F);
      @(posedge pclk);
      timer_zero_async_select <= 1'b0;
   endtask : t_gating

   task automatic t_sleep();
      for (int m = 0; m < 4; m++) begin
         wr(OFF_SLEEP_MODE_CONTROL, 32'(m * 2 + 1));
         core.sleep_op();
         #1;
         chk_bit(sleeping, 1'b1);
         chk_word({30'h0, sleep_mode}, 32'(m));
         wake();
         wr(OFF_SLEEP_MODE_CONTROL, 32'(m * 2));
      end
      @(posedge pclk);
      core.sleep_op();
      #1;
      chk_bit(sleeping, 1'b0);
   endtask : t_sleep

   task automatic t_brownout();
      wr(OFF_SLEEP_MODE_CONTROL, 32'h1);
      wr(OFF_SYSTEM_CONTROL, 32'h40);
      rd_reg(OFF_SYSTEM_CONTROL);
      chk_bit(rd[6], 1'b0);
      @(posedge pclk);
      core.brownout_off_seq();
      rd_reg(OFF_SYSTEM_CONTROL);
      chk_bit(rd[6], 1'b1);
      // Sleep sampled in the first active cycle
      core.sleep_op();
      #1;
      chk_bit(brownout_detector_off, 1'b1);
      wake();
      repeat (8) @(posedge pclk);
      core.brownout_off_seq();
      core.sleep_op();
      #1;
      chk_bit(sleeping, 1'b1);
      chk_bit(brownout_detector_off, 1'b0);
      wake();
      repeat (8) @(posedge pclk);
      core.brownout_off_seq();
      repeat (6) @(posedge pclk);
      core.sleep_op();
      #1;
      chk_bit(brownout_detector_off, 1'b0);
      wake();
      rd_reg(OFF_SYSTEM_CONTROL);
      chk_bit(rd[6], 1'b0);
      wr(OFF_SLEEP_MODE_CONTROL, 32'h0);
   endtask : t_brownout

   task automatic t_flags();
      wr(OFF_PERIPHERAL_CLOCK_GATING, 32'h3F);
      wr(OFF_RESET_CAUSE_FLAGS, 32'h0F);
      rd_reg(OFF_RESET_CAUSE_FLAGS);
      chk_word(rd, 32'h1);
      wr(OFF_RESET_CAUSE_FLAGS, 32'h0);
      rd_reg(OFF_RESET_CAUSE_FLAGS);
      chk_word(rd, 32'h0);
      @(posedge pclk);
      watchdog_reset_pulse <= 1'b1;
      @(posedge pclk);
      watchdog_reset_pulse <= 1'b0;
      #1;
      chk_bit(core_reset_n, 1'b0);
      wait_core();
      chk_bit(n >= 14 && n <= 18, 1'b1);
      rd_reg(OFF_RESET_CAUSE_FLAGS);
      chk_word(rd, 32'h08);
      rd_reg(OFF_PERIPHERAL_CLOCK_GATING);
      chk_word(rd, 32'h0);
      hit(0, 1'b1);
      rd_reg(OFF_RESET_CAUSE_FLAGS);
      chk_word(rd, 32'h0A);
      wr(OFF_RESET_CAUSE_FLAGS, 32'h0);
      brownout_fuse_enable <= 1'b1;
      hit(1, 1'b1);
      rd_reg(OFF_RESET_CAUSE_FLAGS);
      chk_word(rd, 32'h04);
      reset_pin_disable_fuse <= 1'b1;
      brownout_fuse_enable <= 1'b0;
      hit(0, 1'b0);
      hit(1, 1'b0);
      rd_reg(OFF_RESET_CAUSE_FLAGS);
      chk_word(rd, 32'h04);
      hit(2, 1'b1);
      rd_reg(OFF_RESET_CAUSE_FLAGS);
      chk_word(rd, 32'h01);
   endtask : t_flags

   ////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_gating();
      t_sleep();
      t_brownout();
      t_flags();
      stop_test();
   end

   // Whole run needs well under 2000 cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end
endmodule : power_sleep_reset_control_tb
